// ===== src/asfc_pkg.sv
// Shared constants for the frame configuration and alternate status block
package asfc_pkg;
	// ----------------------------------------------------------------
	// Bus geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int IDX_LSB = 2;
	localparam int IDX_MSB = 4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [2:0] IDX_ALT_STATUS = 3'h0;
	localparam logic [2:0] IDX_ALT_IRQ_CTL = 3'h1;
	localparam logic [2:0] IDX_FRAME_CTL = 3'h2;
	localparam logic [2:0] IDX_ALT_DET_CTL = 3'h2;
	localparam logic [2:0] IDX_LINE_CTL = 3'h3;
	localparam logic [2:0] IDX_BANK_CTL = 3'h5;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int FC_RETURN = 7;
	localparam int FC_HALT_WAIT = 6;
	localparam int FC_RX_SOURCE = 5;
	localparam int FC_NINE = 4;
	localparam int FC_MARK = 3;
	localparam int FC_IDLE_ORG = 2;
	localparam int FC_PAR_ON = 1;
	localparam int FC_PAR_ODD = 0;
	localparam int ST_EDGE = 7;
	localparam int ST_MM_LEVEL = 2;
	localparam int ST_MM_FLAG = 1;
	localparam int ST_BREAK = 0;
	localparam int IC_EDGE = 7;
	localparam int IC_MM = 1;
	localparam int IC_BREAK = 0;
	localparam int DC_MM_HI = 2;
	localparam int DC_MM_LO = 1;
	localparam int DC_BRK_ON = 0;
	localparam int LC_TX_EN = 3;
	localparam int LC_RX_ON = 2;
	localparam int BC_ALT = 7;
	localparam int BC_RX_INV = 3;
	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0] FRAME_RST = 8'h00;
	localparam logic [1:0] MM_OFF = 2'h0;
	localparam logic [1:0] MM_EARLY = 2'h1;
	localparam logic [1:0] MM_LATE = 2'h2;
	localparam logic [3:0] MM_TICK_EARLY = 4'h8;
	localparam logic [3:0] MM_TICK_LATE = 4'hC;
	localparam logic [3:0] DBITS_EIGHT = 4'h8;
	localparam logic [3:0] DBITS_NINE = 4'h9;
	typedef enum {SEL_NONE, SEL_FRAME, SEL_STATUS, SEL_IRQ, SEL_DET, SEL_LINE, SEL_BANK} asfc_sel_t;
endpackage

// ===== src/asfc_line_route.sv
// Receive input routing and active edge detection
`timescale 1ns/1ps
`default_nettype none
module asfc_line_route
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic return_path_i,
	input wire logic rx_source_i,
	input wire logic rx_invert_i,
	input wire logic rxd_pin_i,
	input wire logic txd_pin_i,
	input wire logic tx_serial_i,
	output logic rx_line_o,
	output logic rx_edge_o
);
	import asfc_pkg::*;

	logic next_line;
	logic next_edge;

	// Pick the receiver source; with the return path on the pin is ignored
	always_comb
	begin
		if (!return_path_i)
			next_line = rxd_pin_i;
		else if (rx_source_i)
			next_line = txd_pin_i;
		else
			next_line = tx_serial_i;
		// Edge seen as the routed level changes, polarity chosen by software
		if (rx_invert_i)
			next_edge = !rx_line_o && next_line;
		else
			next_edge = rx_line_o && !next_line;
	end

	// Idle line is high, so reset to high to avoid a false edge
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			rx_line_o <= 1'b1;
			rx_edge_o <= 1'b0;
		end
		else
		begin
			rx_line_o <= next_line;
			rx_edge_o <= next_edge;
		end
	end
endmodule
`default_nettype wire

// ===== src/asfc_top.sv
// Frame configuration and alternate status registers of a serial transceiver
//
// Contract
// - Return path on disconnects receive pin; receiver fed from transmit side.
// - Return off normal; on, source 0 internal loop, 1 single-wire pin.
// - Halt-in-wait set stops transceiver in wait mode; clear keeps running.
// - Eight data bits when nine-bit clear, nine when set, one start, stop.
// - Standby wakes on idle line, or on character with MSB set.
// - Parity on generates and checks parity in character MSB.
// - Parity odd 0 even parity, 1 odd parity.
// - Frame register reachable only while bank select is zero.
// - Alternate status register reachable only while bank select is one.
// - Active receive edge sets edge flag, falling or rising per invert.
// - Flags clear on write one; write zero keeps them.
// - Enabled bit-error check sets mismatch flag, requests interrupt if enabled.
// - Mismatch level records sampled receive level at mismatch.
// - Enabled break detector sets break flag, requests interrupt if enabled.
// - Alternate bank visible only while bank select set, else normal bank.
// - Sample point 00 off, 01 ninth tick, 10 thirteenth, 11 reserved.
// - Break flag never raised while break detector is off.
// - Edge flag requests interrupt only while its enable is set.
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module asfc_top
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [asfc_pkg::ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [asfc_pkg::DATA_W-1:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [asfc_pkg::ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [asfc_pkg::DATA_W-1:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic rxd_pin_i,
	input wire logic txd_pin_i,
	input wire logic tx_serial_i,
	input wire logic tx_busy_i,
	input wire logic tx_tick_i,
	input wire logic [3:0] tx_tick_idx_i,
	input wire logic break_rcvd_i,
	input wire logic wait_mode_i,
	input wire logic [8:0] tx_char_i,
	input wire logic [8:0] rx_char_i,
	input wire logic rx_char_valid_i,
	output logic rx_line_o,
	output logic txd_o,
	output logic txd_drive_n_o,
	output logic transceiver_run_o,
	output logic tx_enable_o,
	output logic rx_on_o,
	output logic [3:0] data_bits_o,
	output logic rx_resume_on_mark_o,
	output logic idle_count_origin_o,
	output logic parity_on_o,
	output logic tx_parity_o,
	output logic rx_parity_err_o,
	output logic rx_edge_irq_o,
	output logic mismatch_irq_o,
	output logic break_irq_o
);
	import asfc_pkg::*;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Map an index onto a register; the bank bit remaps only the low three
	function automatic asfc_sel_t reg_sel(input logic [2:0] idx, input logic alt);
		asfc_sel_t s;
		s = SEL_NONE;
		if (idx == IDX_LINE_CTL)
			s = SEL_LINE;
		else if (idx == IDX_BANK_CTL)
			s = SEL_BANK;
		else if (alt && idx == IDX_ALT_STATUS)
			s = SEL_STATUS;
		else if (alt && idx == IDX_ALT_IRQ_CTL)
			s = SEL_IRQ;
		else if (alt && idx == IDX_ALT_DET_CTL)
			s = SEL_DET;
		else if (!alt && idx == IDX_FRAME_CTL)
			s = SEL_FRAME;
		return s;
	endfunction

	// Parity over the data bits below the MSB slot that parity occupies
	function automatic logic parity_of(input logic [8:0] ch, input logic nine, input logic odd);
		logic [7:0] d;
		d = nine ? ch[7:0] : {1'b0, ch[6:0]};
		return (^d) ^ odd;
	endfunction

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [7:0] frame_ctl;
	logic rx_edge_flag, mismatch_flag, mismatch_level, break_seen_flag;
	logic rx_edge_irq_on, mismatch_irq_on, break_irq_on;
	logic [1:0] mismatch_sample_point;
	logic break_detector_on, tx_enable, rx_on, alt_bank_select, rx_invert;
	logic [7:0] next_frame_ctl;
	logic next_rx_edge_flag, next_mismatch_flag, next_mismatch_level, next_break_seen_flag;
	logic next_rx_edge_irq_on, next_mismatch_irq_on, next_break_irq_on;
	logic [1:0] next_mismatch_sample_point;
	logic next_break_detector_on, next_tx_enable, next_rx_on, next_alt_bank_select;
	logic next_rx_invert;
	// Bus state
	logic aw_held, w_held;
	logic [2:0] aw_idx;
	logic [7:0] w_byte;
	logic w_lane;
	logic next_aw_held, next_w_held, next_w_lane;
	logic [2:0] next_aw_idx;
	logic [7:0] next_w_byte;
	logic next_awready, next_wready, next_arready;
	logic next_bvalid, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [DATA_W-1:0] next_rdata;
	logic wr_fire;
	asfc_sel_t wr_sel, rd_sel;
	logic [7:0] rd_byte;
	logic route_edge, mm_hit, mm_sampling;

	// ----------------------------------------------------------------
	// Receive routing and edge detection
	// ----------------------------------------------------------------
	asfc_line_route asfc_line_route_inst
	(
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.return_path_i(frame_ctl[FC_RETURN]),
		.rx_source_i(frame_ctl[FC_RX_SOURCE]),
		.rx_invert_i(rx_invert),
		.rxd_pin_i(rxd_pin_i),
		.txd_pin_i(txd_pin_i),
		.tx_serial_i(tx_serial_i),
		.rx_line_o(rx_line_o),
		.rx_edge_o(route_edge)
	);

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Address and data are caught separately; the write lands once both are in
	always_comb
	begin
		wr_fire = aw_held && w_held && !s_axi_bvalid_o;
		wr_sel = reg_sel(aw_idx, alt_bank_select);
		rd_sel = reg_sel(s_axi_araddr_i[IDX_MSB:IDX_LSB], alt_bank_select);
		next_aw_held = aw_held;
		next_aw_idx = aw_idx;
		next_w_held = w_held;
		next_w_byte = w_byte;
		next_w_lane = w_lane;
		if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			next_aw_held = 1'b1;
			next_aw_idx = s_axi_awaddr_i[IDX_MSB:IDX_LSB];
		end
		if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			next_w_held = 1'b1;
			next_w_byte = s_axi_wdata_i[7:0];
			next_w_lane = s_axi_wstrb_i[0];
		end
		next_bvalid = s_axi_bvalid_o && !s_axi_bready_i;
		next_bresp = s_axi_bresp_o;
		if (wr_fire)
		begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		// Ready stays low from capture until the response is taken
		next_awready = !next_aw_held && !next_bvalid;
		next_wready = !next_w_held && !next_bvalid;
		// Read data is assembled from current state at the address handshake
		case (rd_sel)
			SEL_FRAME: rd_byte = frame_ctl;
			SEL_STATUS: rd_byte = {rx_edge_flag, 4'h0, mismatch_level, mismatch_flag,
				break_seen_flag};
			SEL_IRQ: rd_byte = {rx_edge_irq_on, 5'h00, mismatch_irq_on, break_irq_on};
			SEL_DET: rd_byte = {5'h00, mismatch_sample_point, break_detector_on};
			SEL_LINE: rd_byte = {4'h0, tx_enable, rx_on, 2'h0};
			SEL_BANK: rd_byte = {alt_bank_select, 3'h0, rx_invert, 3'h0};
			default: rd_byte = 8'h00;
		endcase
		next_rvalid = s_axi_rvalid_o && !s_axi_rready_i;
		next_rdata = s_axi_rdata_o;
		next_rresp = s_axi_rresp_o;
		if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			next_rvalid = 1'b1;
			next_rdata = {{(DATA_W-8){1'b0}}, rd_byte};
			next_rresp = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		next_arready = !next_rvalid;
	end

	// Bus registers
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			aw_held <= 1'b0;
			aw_idx <= 3'h0;
			w_held <= 1'b0;
			w_byte <= 8'h00;
			w_lane <= 1'b0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_arready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= {DATA_W{1'b0}};
			s_axi_rresp_o <= RESP_OKAY;
		end
		else
		begin
			aw_held <= next_aw_held;
			aw_idx <= next_aw_idx;
			w_held <= next_w_held;
			w_byte <= next_w_byte;
			w_lane <= next_w_lane;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o <= next_wready;
			s_axi_arready_o <= next_arready;
			s_axi_bvalid_o <= next_bvalid;
			s_axi_bresp_o <= next_bresp;
			s_axi_rvalid_o <= next_rvalid;
			s_axi_rdata_o <= next_rdata;
			s_axi_rresp_o <= next_rresp;
		end
	end

	// ----------------------------------------------------------------
	// Control registers and event flags
	// ----------------------------------------------------------------
	// Events are applied after the clear so a same-cycle set is never lost
	always_comb
	begin
		next_frame_ctl = frame_ctl;
		next_rx_edge_flag = rx_edge_flag;
		next_mismatch_flag = mismatch_flag;
		next_mismatch_level = mismatch_level;
		next_break_seen_flag = break_seen_flag;
		next_rx_edge_irq_on = rx_edge_irq_on;
		next_mismatch_irq_on = mismatch_irq_on;
		next_break_irq_on = break_irq_on;
		next_mismatch_sample_point = mismatch_sample_point;
		next_break_detector_on = break_detector_on;
		next_tx_enable = tx_enable;
		next_rx_on = rx_on;
		next_alt_bank_select = alt_bank_select;
		next_rx_invert = rx_invert;
		// Only the low byte lane carries register bits
		if (wr_fire && w_lane)
		begin
			case (wr_sel)
				SEL_FRAME: next_frame_ctl = w_byte;
				SEL_STATUS:
				begin
					// Bits six to three have no storage, so writes there vanish
					if (w_byte[ST_EDGE])
						next_rx_edge_flag = 1'b0;
					if (w_byte[ST_MM_FLAG])
						next_mismatch_flag = 1'b0;
					if (w_byte[ST_BREAK])
						next_break_seen_flag = 1'b0;
				end
				SEL_IRQ:
				begin
					next_rx_edge_irq_on = w_byte[IC_EDGE];
					next_mismatch_irq_on = w_byte[IC_MM];
					next_break_irq_on = w_byte[IC_BREAK];
				end
				SEL_DET:
				begin
					next_mismatch_sample_point = w_byte[DC_MM_HI:DC_MM_LO];
					next_break_detector_on = w_byte[DC_BRK_ON];
				end
				SEL_LINE:
				begin
					next_tx_enable = w_byte[LC_TX_EN];
					next_rx_on = w_byte[LC_RX_ON];
				end
				SEL_BANK:
				begin
					next_alt_bank_select = w_byte[BC_ALT];
					next_rx_invert = w_byte[BC_RX_INV];
				end
				default: next_frame_ctl = frame_ctl;
			endcase
		end
		if (route_edge)
			next_rx_edge_flag = 1'b1;
		if (mm_hit)
		begin
			next_mismatch_flag = 1'b1;
			next_mismatch_level = rx_line_o;
		end
		if (break_rcvd_i && break_detector_on)
			next_break_seen_flag = 1'b1;
	end

	// All control fields and flags start cleared
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			frame_ctl <= FRAME_RST;
			rx_edge_flag <= 1'b0;
			mismatch_flag <= 1'b0;
			mismatch_level <= 1'b0;
			break_seen_flag <= 1'b0;
			rx_edge_irq_on <= 1'b0;
			mismatch_irq_on <= 1'b0;
			break_irq_on <= 1'b0;
			mismatch_sample_point <= MM_OFF;
			break_detector_on <= 1'b0;
			tx_enable <= 1'b0;
			rx_on <= 1'b0;
			alt_bank_select <= 1'b0;
			rx_invert <= 1'b0;
		end
		else
		begin
			frame_ctl <= next_frame_ctl;
			rx_edge_flag <= next_rx_edge_flag;
			mismatch_flag <= next_mismatch_flag;
			mismatch_level <= next_mismatch_level;
			break_seen_flag <= next_break_seen_flag;
			rx_edge_irq_on <= next_rx_edge_irq_on;
			mismatch_irq_on <= next_mismatch_irq_on;
			break_irq_on <= next_break_irq_on;
			mismatch_sample_point <= next_mismatch_sample_point;
			break_detector_on <= next_break_detector_on;
			tx_enable <= next_tx_enable;
			rx_on <= next_rx_on;
			alt_bank_select <= next_alt_bank_select;
			rx_invert <= next_rx_invert;
		end
	end

	// ----------------------------------------------------------------
	// Bit-error sampling
	// ----------------------------------------------------------------
	// Reserved code 11 is treated as off so it can never flag
	always_comb
	begin
		case (mismatch_sample_point)
			MM_EARLY: mm_sampling = tx_tick_idx_i == MM_TICK_EARLY;
			MM_LATE: mm_sampling = tx_tick_idx_i == MM_TICK_LATE;
			default: mm_sampling = 1'b0;
		endcase
		mm_hit = tx_busy_i && tx_tick_i && mm_sampling && (rx_line_o != tx_serial_i);
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (sys_rst_i)
		begin
			txd_o <= 1'b1;
			txd_drive_n_o <= 1'b1;
			transceiver_run_o <= 1'b1;
			data_bits_o <= DBITS_EIGHT;
			tx_parity_o <= 1'b0;
			rx_parity_err_o <= 1'b0;
			rx_edge_irq_o <= 1'b0;
			mismatch_irq_o <= 1'b0;
			break_irq_o <= 1'b0;
		end
		else
		begin
			txd_o <= tx_serial_i;
			txd_drive_n_o <= !tx_enable;
			transceiver_run_o <= !(wait_mode_i && frame_ctl[FC_HALT_WAIT]);
			data_bits_o <= frame_ctl[FC_NINE] ? DBITS_NINE : DBITS_EIGHT;
			tx_parity_o <= parity_of(tx_char_i, frame_ctl[FC_NINE], frame_ctl[FC_PAR_ODD]);
			// Check is a one-cycle pulse, only for a new character
			rx_parity_err_o <= rx_char_valid_i && frame_ctl[FC_PAR_ON]
				&& (parity_of(rx_char_i, frame_ctl[FC_NINE], frame_ctl[FC_PAR_ODD])
				!= (frame_ctl[FC_NINE] ? rx_char_i[8] : rx_char_i[7]));
			rx_edge_irq_o <= rx_edge_flag && rx_edge_irq_on;
			mismatch_irq_o <= mismatch_flag && mismatch_irq_on;
			break_irq_o <= break_seen_flag && break_irq_on;
		end
	end

	// Frame shape and receiver settings handed to the shifters
	assign tx_enable_o = tx_enable;
	assign rx_on_o = rx_on;
	assign rx_resume_on_mark_o = frame_ctl[FC_MARK];
	assign idle_count_origin_o = frame_ctl[FC_IDLE_ORG];
	assign parity_on_o = frame_ctl[FC_PAR_ON];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [2:0] rd_idx_q;
	always_ff @(posedge clk_i)
	begin
		if (s_axi_arvalid_i && s_axi_arready_o)
			rd_idx_q <= s_axi_araddr_i[IDX_MSB:IDX_LSB];
	end
	AST_EDGE_SETS: assert property (route_edge |=> rx_edge_flag)
		else $error("edge flag not set after active edge");
	AST_W1C_CLEAR: assert property (wr_fire && w_lane && wr_sel == SEL_STATUS && w_byte[ST_EDGE]
		&& !route_edge |=> !rx_edge_flag)
		else $error("edge flag not cleared by write one");
	AST_ZERO_KEEPS: assert property (wr_fire && wr_sel == SEL_STATUS && !w_byte[ST_MM_FLAG]
		&& mismatch_flag |=> mismatch_flag)
		else $error("mismatch flag lost on write zero");
	AST_MISMATCH: assert property (mm_hit |=> mismatch_flag && mismatch_level == $past(rx_line_o))
		else $error("mismatch not recorded");
	AST_NO_BREAK: assert property (!break_detector_on && !break_seen_flag |=> !break_seen_flag)
		else $error("break flag raised while detector off");
	AST_EDGE_IRQ: assert property (##1 rx_edge_irq_o == $past(rx_edge_flag && rx_edge_irq_on))
		else $error("edge interrupt not gated by enable");
	AST_WAIT_HALT: assert property (wait_mode_i && frame_ctl[FC_HALT_WAIT] |=> !transceiver_run_o)
		else $error("transceiver still running in wait");
	AST_SINGLE_WIRE: assert property (frame_ctl[FC_RETURN] && frame_ctl[FC_RX_SOURCE]
		|=> rx_line_o == $past(txd_pin_i))
		else $error("single wire routing wrong");
	AST_RSVD_ZERO: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_OKAY
		&& rd_idx_q == IDX_ALT_STATUS && alt_bank_select |-> s_axi_rdata_o[6:3] == 4'h0)
		else $error("reserved status bits not zero");
	AST_BANK_GUARD: assert property (wr_fire && aw_idx == IDX_FRAME_CTL && alt_bank_select
		|=> $stable(frame_ctl))
		else $error("frame register written in alternate bank");
	COV_EDGE: cover property (route_edge ##1 rx_edge_flag);
	COV_MISMATCH: cover property (mm_hit ##1 mismatch_irq_o [*2]);
	COV_SINGLE_WIRE: cover property (frame_ctl[FC_RETURN] && frame_ctl[FC_RX_SOURCE] && tx_busy_i);
	COV_BREAK: cover property (break_rcvd_i && break_detector_on ##2 break_irq_o);
endmodule
`default_nettype wire

// ===== dv/asfc_remote_node.sv
// Remote serial node model on the line side
`timescale 1ns/1ps
`default_nettype none
module asfc_remote_node
(
	input wire logic clk_i,
	input wire logic send_low_i,
	input wire logic txd_i,
	input wire logic txd_drive_n_i,
	output logic rxd_o,
	output logic txd_pin_o
);
	// Pulled-up line: when released it reads high, never the last value
	always_ff @(posedge clk_i)
	begin
		rxd_o <= !send_low_i;
	end
	// Shared single-wire pin, pulled high while the device lets it go
	assign txd_pin_o = txd_drive_n_i ? 1'b1 : txd_i;
endmodule
`default_nettype wire

// ===== dv/async_serial_frame_config_status_test.sv
// Self-checking bench for the frame configuration and alternate status block
`timescale 1ns/1ps
`default_nettype none
module async_serial_frame_config_status_test;
	import asfc_pkg::*;
	logic clk_i = 0, sys_rst_i = 1, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
	logic [DATA_W-1:0] wdata = '0, rdata;
	logic [3:0] strb = 4'h1, dbits;
	logic [1:0] bresp, rresp;
	logic awready, wready, bvalid, arready, rvalid, rxd, txd_pin, txd, txd_dn, run, rx_line;
	logic send_low = 0, tx_serial = 1, brk = 0, wmode = 0, tx_par, b_irq;
	logic [8:0] tx_char = 9'h083;
	logic busy = 0, tk = 0, rxv = 0, ten, ron, mark, idle_count_origin, pon, p_err, e_irq, m_irq;
	logic [3:0] tidx = 4'h0;
	int err_count = 0, cmp_count = 0;
	asfc_top asfc_top_inst (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(awaddr),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
		.s_axi_rready_i(rready), .rxd_pin_i(rxd), .txd_pin_i(txd_pin),
		.tx_serial_i(tx_serial), .tx_busy_i(busy), .tx_tick_i(tk), .tx_tick_idx_i(tidx),
		.break_rcvd_i(brk), .wait_mode_i(wmode), .tx_char_i(tx_char), .rx_char_i(tx_char),
		.rx_char_valid_i(rxv), .rx_line_o(rx_line), .txd_o(txd), .txd_drive_n_o(txd_dn),
		.transceiver_run_o(run), .tx_enable_o(ten), .rx_on_o(ron), .data_bits_o(dbits),
		.rx_resume_on_mark_o(mark), .idle_count_origin_o(idle_count_origin), .parity_on_o(pon),
		.tx_parity_o(tx_par), .rx_parity_err_o(p_err), .rx_edge_irq_o(e_irq),
		.mismatch_irq_o(m_irq), .break_irq_o(b_irq));
	asfc_remote_node asfc_remote_node_inst (.clk_i(clk_i), .send_low_i(send_low),
		.txd_i(txd), .txd_drive_n_i(txd_dn), .rxd_o(rxd), .txd_pin_o(txd_pin));
	// ----------------------------------------------------------------
	// Common tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("Counts: %0d mismatches, %0d comparisons", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// One bus transfer; readiness is sampled mid-cycle, so the edge never races
	task automatic bus(input bit w, input logic [2:0] i, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] rs);
		logic ta, tw, tr, done;
		@(posedge clk_i);
		awaddr <= {i, 2'h0};
		araddr <= {i, 2'h0};
		wdata <= {24'h00_0000, d};
		{awv, wv, bready} <= {3{w}};
		{arv, rready} <= {2{!w}};
		done = 0;
		while (!done)
		begin
			@(negedge clk_i);
			ta = awv && awready;
			tw = wv && wready;
			tr = arv && arready;
			done = w ? (bvalid && bready) : (rvalid && rready);
			q = rdata;
			rs = w ? bresp : rresp;
			@(posedge clk_i);
			if (ta) awv <= 1'b0;
			if (tw) wv <= 1'b0;
			if (tr) arv <= 1'b0;
			bready <= bready && !done;
			rready <= rready && !done;
		end
	endtask
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		logic [31:0] q;
		logic [1:0] rs;
		bus(1'b1, i, d, q, rs);
	endtask
	task automatic rd(input logic [2:0] i, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] rs;
		bus(1'b0, i, 8'h00, q, rs);
		chk(q, e);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task automatic pulse_break();
		@(posedge clk_i);
		brk <= 1'b1;
		@(posedge clk_i);
		brk <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_frame();
		rd(IDX_FRAME_CTL, 32'h0000_0000, RESP_OKAY);
		chk(dbits, DBITS_EIGHT);
		wr(IDX_FRAME_CTL, 8'h5A);
		rd(IDX_FRAME_CTL, 32'h0000_005A, RESP_OKAY);
		chk(dbits, DBITS_NINE);
		chk({mark, idle_count_origin, pon}, 3'h5);
		@(posedge clk_i);
		strb <= 4'h0;
		wr(IDX_FRAME_CTL, 8'hFF);
		strb <= 4'h1;
		rd(IDX_FRAME_CTL, 32'h0000_005A, RESP_OKAY);
		rd(3'h4, 32'h0000_0000, RESP_SLVERR);
		rd(IDX_ALT_STATUS, 32'h0000_0000, RESP_SLVERR);
	endtask
	// Halt-in-wait is set by the previous scenario
	task automatic t_wait();
		@(posedge clk_i);
		wmode <= 1'b1;
		tick(3);
		chk(run, 1'b0);
		wr(IDX_FRAME_CTL, 8'h1A);
		tick(2);
		chk(run, 1'b1);
		@(posedge clk_i);
		wmode <= 1'b0;
	endtask
	// Character 0x83: three ones in eight bits, two in seven
	task automatic t_parity();
		for (int k = 0; k < 2; k++)
		begin
			wr(IDX_FRAME_CTL, 8'h12 | 8'(k));
			tick(2);
			chk(tx_par, !k[0]);
		end
		wr(IDX_FRAME_CTL, 8'h02);
		tick(2);
		chk(tx_par, 1'b0);
		// Received 0x83 in eight-bit even parity carries a wrong MSB
		@(posedge clk_i);
		rxv <= 1'b1;
		@(posedge clk_i);
		rxv <= 1'b0;
		tick(1);
		chk(p_err, 1'b1);
	endtask
	// Both directions are enabled before any loop use
	task automatic t_route();
		wr(IDX_LINE_CTL, 8'h0C);
		chk({ten, ron}, 2'h3);
		for (int s = 0; s < 2; s++)
		begin
			wr(IDX_FRAME_CTL, 8'h80 | 8'(s << FC_RX_SOURCE));
			tx_serial <= 1'b0;
			tick(4);
			chk(rx_line, 1'b0);
			@(posedge clk_i);
			tx_serial <= 1'b1;
		end
		wr(IDX_FRAME_CTL, 8'h00);
		tx_serial <= 1'b0;
		tick(4);
		chk(rx_line, 1'b1);
		@(posedge clk_i);
		tx_serial <= 1'b1;
	endtask
	task automatic t_alt();
		wr(IDX_BANK_CTL, 8'h88);
		wr(IDX_ALT_STATUS, 8'hFF);
		rd(IDX_ALT_STATUS, 32'h0000_0000, RESP_OKAY);
		// The flag lands three edges after the line moves, so let it settle
		send_low <= 1'b1;
		tick(3);
		rd(IDX_ALT_STATUS, 32'h0000_0000, RESP_OKAY);
		send_low <= 1'b0;
		tick(3);
		rd(IDX_ALT_STATUS, 32'h0000_0080, RESP_OKAY);
		chk(e_irq, 1'b0);
		wr(IDX_ALT_STATUS, 8'h78);
		rd(IDX_ALT_STATUS, 32'h0000_0080, RESP_OKAY);
		wr(IDX_BANK_CTL, 8'h80);
		wr(IDX_ALT_STATUS, 8'h80);
		rd(IDX_ALT_STATUS, 32'h0000_0000, RESP_OKAY);
		send_low <= 1'b1;
		tick(3);
		rd(IDX_ALT_STATUS, 32'h0000_0080, RESP_OKAY);
		send_low <= 1'b0;
		wr(IDX_ALT_STATUS, 8'h80);
		pulse_break();
		rd(IDX_ALT_STATUS, 32'h0000_0000, RESP_OKAY);
		wr(IDX_ALT_DET_CTL, 8'h01);
		wr(IDX_ALT_IRQ_CTL, 8'h01);
		pulse_break();
		rd(IDX_ALT_STATUS, 32'h0000_0001, RESP_OKAY);
		chk(b_irq, 1'b1);
		wr(IDX_ALT_STATUS, 8'h01);
		tick(2);
		chk(b_irq, 1'b0);
	endtask
	// Transmit low against a high line; only the selected tick may sample it
	task automatic t_mismatch();
		wr(IDX_ALT_DET_CTL, 8'h02);
		wr(IDX_ALT_IRQ_CTL, 8'h02);
		tx_serial <= 1'b0;
		{busy, tk, tidx} <= {2'h3, MM_TICK_LATE};
		rd(IDX_ALT_STATUS, 32'h0000_0000, RESP_OKAY);
		tidx <= MM_TICK_EARLY;
		@(posedge clk_i);
		{busy, tk, tx_serial} <= 3'h1;
		rd(IDX_ALT_STATUS, 32'h0000_0006, RESP_OKAY);
		chk(m_irq, 1'b1);
	endtask
	// ----------------------------------------------------------------
	// Clock, reset, watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		forever #4 clk_i = !clk_i;
	end
	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		stop_test();
	end
	initial
	begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_frame();
		t_wait();
		t_parity();
		t_route();
		t_alt();
		t_mismatch();
		stop_test();
	end
endmodule
`default_nettype wire
